// ---- ess_consts.svh ----
`ifndef ESS_CONSTS_SVH
`define ESS_CONSTS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define ESS_CLK_PERIOD_NS 8
`define ESS_TICK_TIME_NS 1000000
`define ESS_TICK_CYCLES (`ESS_TICK_TIME_NS / `ESS_CLK_PERIOD_NS)
`define ESS_GATE_TICKS 4'hA
`define ESS_DELAY_UNIT_MS 16'h0064

// ----------------------------------------
// speed scaling
// ----------------------------------------
`define ESS_FB_SCALE 48'h0000000F4240
`define ESS_LEVEL_SCALE 48'h000000000064
`define ESS_MIN_REF 16'h0064
`define ESS_DIGIT_HUNDRED 8'h64

`endif

// ---- ess_pkg.sv ----
package ess_pkg;
    timeunit 1ns;
    timeprecision 1ps;
    typedef enum logic [1:0] {
        ESS_DECEL = 2'b00,
        ESS_COAST = 2'b01,
        ESS_FAST  = 2'b10,
        ESS_ALARM = 2'b11
    } ess_stop_t;
endpackage

// ---- ess_supervisor.sv ----
`include "ess_consts.svh"

module ess_supervisor #(
    parameter int TICK_CYCLES = `ESS_TICK_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // encoder pins
    input wire logic enc_a_i,
    input wire logic enc_b_i,
    // drive state
    input wire logic run_i,
    input wire logic dc_brake_i,
    input wire logic speed_agree_i,
    input wire logic signed [15:0] speed_ref_i,
    input wire logic [15:0] max_rev_per_s_i,
    input wire logic complementary_variant_i,
    input wire logic fault_reset_i,
    // settings
    input wire logic [15:0] pulses_per_rev_i,
    input wire logic direction_polarity_i,
    input wire logic [7:0] monitor_divider_setting_i,
    input wire logic [7:0] open_detect_time_i,
    input wire ess_pkg::ess_stop_t open_fault_stop_method_i,
    input wire logic [6:0] overspeed_level_i,
    input wire logic [4:0] overspeed_delay_i,
    input wire ess_pkg::ess_stop_t overspeed_stop_method_i,
    input wire logic [5:0] speed_error_level_i,
    input wire logic [6:0] speed_error_delay_i,
    input wire ess_pkg::ess_stop_t speed_error_stop_method_i,
    // results
    output logic monitor_pulse_o,
    output logic signed [16:0] speed_count_o,
    output logic encoder_open_fault_o,
    output logic overspeed_fault_o,
    output logic speed_error_fault_o,
    output logic stop_req_o,
    output ess_pkg::ess_stop_t stop_method_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import ess_pkg::*;

    function automatic logic [15:0] mag16(input logic signed [16:0] v);
        logic signed [16:0] t;
        t = (v < 0) ? -v : v;
        return t[15:0];
    endfunction

    // ----------------------------------------
    // pin synchronisers and edges
    // ----------------------------------------
    logic [1:0] a_sync_q, b_sync_q;
    logic a_last_q, b_last_q;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            a_sync_q <= 2'h0;
            b_sync_q <= 2'h0;
            a_last_q <= 1'b0;
            b_last_q <= 1'b0;
        end else begin
            a_sync_q <= {a_sync_q[0], enc_a_i};
            b_sync_q <= {b_sync_q[0], enc_b_i};
            a_last_q <= a_sync_q[1];
            b_last_q <= b_sync_q[1];
        end
    end
    wire logic a_rise = a_sync_q[1] & ~a_last_q;
    wire logic a_edge = a_sync_q[1] ^ a_last_q;
    wire logic any_edge = a_edge | (b_sync_q[1] ^ b_last_q);
    // a rising while b low means a leads
    wire logic fwd_pulse = ~b_sync_q[1] ^ direction_polarity_i;

    // ----------------------------------------
    // tick and speed gate
    // ----------------------------------------
    logic [31:0] tick_cnt_q;
    logic [3:0] gate_cnt_q;
    logic tick;
    logic signed [16:0] acc_q;
    assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));
    wire logic gate_end = tick & (gate_cnt_q == `ESS_GATE_TICKS - 4'h1);
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tick_cnt_q <= 32'h0;
            gate_cnt_q <= 4'h0;
        end else begin
            tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
            if (tick) begin
                gate_cnt_q <= gate_end ? 4'h0 : gate_cnt_q + 4'h1;
            end
        end
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            acc_q <= 17'sh0;
            speed_count_o <= 17'sh0;
        end else if (gate_end) begin
            speed_count_o <= acc_q;
            acc_q <= a_rise ? (fwd_pulse ? 17'sh1 : -17'sh1) : 17'sh0;
        end else if (a_rise) begin
            acc_q <= fwd_pulse ? acc_q + 17'sh1 : acc_q - 17'sh1;
        end
    end

    // ----------------------------------------
    // scaled speed comparisons
    // ----------------------------------------
    logic [47:0] ppr_max, fb_mag, ref_mag, os_lim, dev_lim;
    logic signed [48:0] err_s;
    logic [47:0] err_mag;
    logic fb_neg, ref_neg;
    always_comb begin
        ppr_max = 48'(max_rev_per_s_i) * 48'(pulses_per_rev_i);
        fb_mag = 48'(mag16(speed_count_o)) * `ESS_FB_SCALE;
        ref_mag = 48'(mag16(17'(speed_ref_i))) * ppr_max;
        fb_neg = speed_count_o < 0;
        ref_neg = speed_ref_i < 0;
        os_lim = 48'(48'(overspeed_level_i) * `ESS_LEVEL_SCALE * ppr_max);
        dev_lim = 48'(48'(speed_error_level_i) * `ESS_LEVEL_SCALE * ppr_max);
        err_s = (ref_neg ? -$signed({1'b0, ref_mag}) : $signed({1'b0, ref_mag}))
              - (fb_neg ? -$signed({1'b0, fb_mag}) : $signed({1'b0, fb_mag}));
        err_mag = err_s < 0 ? 48'(-err_s) : 48'(err_s);
    end

    // ----------------------------------------
    // speed error arming
    // ----------------------------------------
    logic armed_q;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            armed_q <= 1'b0;
        end else if (!run_i) begin
            armed_q <= 1'b0;
        end else if (speed_agree_i) begin
            armed_q <= 1'b1;
        end
    end

    // ----------------------------------------
    // fault qualification: 0 open, 1 overspeed, 2 speed error
    // ----------------------------------------
    logic [2:0] cond, restart, fault_q;
    logic [15:0] lim_ms [3];
    logic [15:0] tmr_q [3];
    always_comb begin
        cond[0] = run_i & !dc_brake_i & (mag16(17'(speed_ref_i)) >= `ESS_MIN_REF);
        cond[1] = fb_mag > os_lim;
        cond[2] = armed_q & (err_mag > dev_lim);
        restart = ~cond | {2'b00, any_edge};
        lim_ms[0] = 16'(open_detect_time_i) * `ESS_DELAY_UNIT_MS;
        lim_ms[1] = 16'(overspeed_delay_i) * `ESS_DELAY_UNIT_MS;
        lim_ms[2] = 16'(speed_error_delay_i) * `ESS_DELAY_UNIT_MS;
    end
    for (genvar i = 0; i < 3; i++) begin : g_qual
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                tmr_q[i] <= 16'h0;
            end else if (restart[i]) begin
                tmr_q[i] <= 16'h0;
            end else if (tick && tmr_q[i] != 16'hFFFF) begin
                tmr_q[i] <= tmr_q[i] + 16'h1;
            end
        end
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                fault_q[i] <= 1'b0;
            end else if (!restart[i] && tick && tmr_q[i] >= lim_ms[i]) begin
                fault_q[i] <= 1'b1;
            end else if (fault_reset_i) begin
                fault_q[i] <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // fault outputs and stop action
    // ----------------------------------------
    ess_stop_t method_d;
    always_comb begin
        if (fault_q[0]) begin
            method_d = open_fault_stop_method_i;
        end else if (fault_q[1]) begin
            method_d = overspeed_stop_method_i;
        end else begin
            method_d = speed_error_stop_method_i;
        end
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            encoder_open_fault_o <= 1'b0;
            overspeed_fault_o <= 1'b0;
            speed_error_fault_o <= 1'b0;
            stop_req_o <= 1'b0;
            stop_method_o <= ESS_ALARM;
        end else begin
            encoder_open_fault_o <= fault_q[0];
            overspeed_fault_o <= fault_q[1];
            speed_error_fault_o <= fault_q[2];
            stop_req_o <= (|fault_q) && method_d != ESS_ALARM;
            stop_method_o <= (|fault_q) ? method_d : ESS_ALARM;
        end
    end

    // ----------------------------------------
    // pulse monitor divider
    // ----------------------------------------
    logic div_hi;
    logic [7:0] div_m;
    logic [1:0] div_step;
    logic [7:0] div_acc_q, div_sum;
    always_comb begin
        div_hi = monitor_divider_setting_i >= `ESS_DIGIT_HUNDRED;
        div_m = div_hi ? monitor_divider_setting_i - `ESS_DIGIT_HUNDRED
                       : monitor_divider_setting_i;
        if (div_m == 8'h00) begin
            div_m = 8'h01;
        end else if (div_m > 8'h20) begin
            div_m = 8'h20;
        end
        div_step = (div_hi && div_m != 8'h01) ? 2'h2 : 2'h1;
        div_sum = div_acc_q + 8'(div_step);
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_acc_q <= 8'h00;
            monitor_pulse_o <= 1'b0;
        end else if (!complementary_variant_i) begin
            div_acc_q <= 8'h00;
            monitor_pulse_o <= 1'b0;
        end else if (a_edge) begin
            if (div_sum >= div_m) begin
                div_acc_q <= div_sum - div_m;
                monitor_pulse_o <= ~monitor_pulse_o;
            end else begin
                div_acc_q <= div_sum;
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    open_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(fault_q[0]) |-> $past(cond[0]) && !$past(any_edge))
        else $error("open fault without cause");
    os_delay_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(fault_q[1]) |-> $past(cond[1]) && $past(tmr_q[1]) >= $past(lim_ms[1]))
        else $error("overspeed fault before delay");
    dev_armed_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !armed_q && !fault_q[2] |=> !fault_q[2])
        else $error("speed error fault while unarmed");
    dev_delay_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(fault_q[2]) |-> $past(tmr_q[2]) >= $past(lim_ms[2]) && $past(tick))
        else $error("speed error fault before delay");
    timer_restart_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !cond[1] |=> tmr_q[1] == 16'h0)
        else $error("timer not restarted");
    open_method_a: assert property (@(posedge clk_i) disable iff (rst_i)
        fault_q[0] && $stable(open_fault_stop_method_i)
        |=> stop_method_o == $past(open_fault_stop_method_i))
        else $error("open stop method wrong");
    os_method_a: assert property (@(posedge clk_i) disable iff (rst_i)
        fault_q == 3'b010 |=> stop_method_o == $past(overspeed_stop_method_i))
        else $error("overspeed stop method wrong");
    dev_method_a: assert property (@(posedge clk_i) disable iff (rst_i)
        fault_q == 3'b100 |=> stop_method_o == $past(speed_error_stop_method_i)
        && stop_req_o == ($past(speed_error_stop_method_i) != ESS_ALARM))
        else $error("speed error stop method wrong");
    monitor_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !complementary_variant_i |=> !monitor_pulse_o)
        else $error("monitor active on line-driver variant");
    cov_open_c: cover property (@(posedge clk_i) disable iff (rst_i) $rose(fault_q[0]));
    cov_os_c: cover property (@(posedge clk_i) disable iff (rst_i) $rose(fault_q[1]));
    cov_dev_c: cover property (@(posedge clk_i) disable iff (rst_i) $rose(fault_q[2]));
    cov_mon_c: cover property (@(posedge clk_i) disable iff (rst_i) $rose(monitor_pulse_o));
endmodule

// ---- ess_enc_model.sv ----
module ess_enc_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // motion control
    input wire logic step_en_i,
    input wire logic a_leads_i,
    input wire logic [15:0] quarter_i,
    // encoder phases
    output logic enc_a_o,
    output logic enc_b_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // quadrature stepping
    // ----------------------------------------
    logic [15:0] div_q;
    logic [1:0] phase_q;
    // one phase step per quarter period while moving, levels held when stopped
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_q <= 16'h0000;
            phase_q <= 2'h0;
        end else if (step_en_i) begin
            if (div_q >= quarter_i - 16'h0001) begin
                div_q <= 16'h0000;
                phase_q <= a_leads_i ? phase_q + 2'h1 : phase_q - 2'h1;
            end else begin
                div_q <= div_q + 16'h0001;
            end
        end
    end
    // gray code: a leads b while the phase counts up
    assign enc_a_o = phase_q[1] ^ phase_q[0];
    assign enc_b_o = phase_q[1];
endmodule

// ---- tb.sv ----
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ess_pkg::*;
    // ----------------------------------------
    // stimulus and results
    // ----------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic enc_en = 1'b0;
    logic a_leads = 1'b1;
    logic [15:0] quarter = 16'h0005;
    logic run = 1'b0, brake = 1'b0, agree = 1'b0, cvar = 1'b0, frst = 1'b0, pol = 1'b0;
    logic signed [15:0] sref = 16'h0000;
    logic [15:0] ppr = 16'h0001;
    logic [15:0] maxf = 16'h03E8;
    logic [7:0] mdiv = 8'h01, odt = 8'h01;
    logic [6:0] oslvl = 7'h78, sedly = 7'h00;
    logic [4:0] osdly = 5'h00;
    logic [5:0] selvl = 6'h0A;
    ess_stop_t ostop = ESS_COAST, osstop = ESS_DECEL, sestop = ESS_FAST, stop_m;
    logic enc_a, enc_b, mon, open_f, os_f, dev_f, stop_req;
    logic mon_prev = 1'b0;
    logic signed [16:0] cnt;
    logic [7:0] mtab [7] = '{8'h01, 8'h02, 8'h20, 8'h84, 8'h65, 8'h00, 8'h02};
    logic [7:0] mexp [7] = '{8'h40, 8'h20, 8'h02, 8'h04, 8'h40, 8'h40, 8'h00};
    int failures = 0, n_tests = 0, toggles = 0, t0;

    initial begin
        forever #4 clk = ~clk;
    end

    ess_enc_model i_enc (
        .clk_i(clk), .rst_i(rst), .step_en_i(enc_en), .a_leads_i(a_leads),
        .quarter_i(quarter), .enc_a_o(enc_a), .enc_b_o(enc_b)
    );

    ess_supervisor #(.TICK_CYCLES(10)) i_dut (
        .clk_i(clk), .rst_i(rst), .enc_a_i(enc_a), .enc_b_i(enc_b), .run_i(run),
        .dc_brake_i(brake), .speed_agree_i(agree), .speed_ref_i(sref),
        .max_rev_per_s_i(maxf), .complementary_variant_i(cvar),
        .fault_reset_i(frst), .pulses_per_rev_i(ppr), .direction_polarity_i(pol),
        .monitor_divider_setting_i(mdiv), .open_detect_time_i(odt),
        .open_fault_stop_method_i(ostop), .overspeed_level_i(oslvl),
        .overspeed_delay_i(osdly), .overspeed_stop_method_i(osstop),
        .speed_error_level_i(selvl), .speed_error_delay_i(sedly),
        .speed_error_stop_method_i(sestop), .monitor_pulse_o(mon), .speed_count_o(cnt),
        .encoder_open_fault_o(open_f), .overspeed_fault_o(os_f),
        .speed_error_fault_o(dev_f), .stop_req_o(stop_req), .stop_method_o(stop_m)
    );

    // monitor edge counter
    always @(posedge clk) begin
        mon_prev <= mon;
        if (mon !== mon_prev) begin
            toggles <= toggles + 1;
        end
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %0h got %0h", what, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic look(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic clear_faults();
        repeat (20) @(posedge clk);
        frst <= 1'b1;
        @(posedge clk);
        frst <= 1'b0;
    endtask

    task automatic wait_flag(input int k, input int lim);
        int i;
        logic f;
        i = 0;
        f = 1'b0;
        while (f !== 1'b1 && i < lim) begin
            @(negedge clk);
            f = (k == 0) ? open_f : (k == 1) ? os_f : dev_f;
            i++;
        end
        check("fault raised", 32'h1, {31'h0, f});
        if (f !== 1'b1) begin
            end_sim();
        end
    endtask

    task automatic check_stop(input ess_stop_t m);
        check("stop method", {30'h0, m}, {30'h0, stop_m});
        check("stop request", {31'h0, m != ESS_ALARM}, {31'h0, stop_req});
    endtask

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        // monitor divider table, 64 a edges from a fresh accumulator
        for (int i = 0; i < 7; i++) begin
            @(posedge clk);
            rst <= 1'b1;
            mdiv <= mtab[i];
            cvar <= (i != 6);
            repeat (6) @(posedge clk);
            rst <= 1'b0;
            repeat (4) @(posedge clk);
            t0 = toggles;
            enc_en <= 1'b1;
            repeat (640) @(posedge clk);
            enc_en <= 1'b0;
            look(10);
            check("monitor toggles", {24'h0, mexp[i]}, toggles - t0);
        end
        // count sign from phase order and polarity
        @(posedge clk);
        enc_en <= 1'b1;
        look(300);
        check("count fwd", 32'h00000005, 32'(cnt));
        @(posedge clk);
        pol <= 1'b1;
        look(300);
        check("count polarity", 32'hFFFFFFFB, 32'(cnt));
        @(posedge clk);
        a_leads <= 1'b0;
        look(300);
        check("count b leads", 32'h00000005, 32'(cnt));
        @(posedge clk);
        a_leads <= 1'b1;
        pol <= 1'b0;
        look(300);
        check("count fwd again", 32'h00000005, 32'(cnt));
        // overspeed with each stop method, level boundary at 50 percent
        for (int m = 0; m < 4; m++) begin
            @(posedge clk);
            osstop <= ess_stop_t'(m[1:0]);
            oslvl <= 7'h31;
            wait_flag(1, 1500);
            check_stop(ess_stop_t'(m[1:0]));
            @(posedge clk);
            oslvl <= 7'h32;
            clear_faults();
            look(300);
            check("os at level", 32'h0, {31'h0, os_f});
        end
        @(posedge clk);
        ppr <= 16'h0002;
        oslvl <= 7'h19;
        look(300);
        check("os scaled", 32'h0, {31'h0, os_f});
        @(posedge clk);
        ppr <= 16'h0001;
        maxf <= 16'h07D0;
        look(300);
        check("os max scaled", 32'h0, {31'h0, os_f});
        @(posedge clk);
        maxf <= 16'h03E8;
        ppr <= 16'h0001;
        oslvl <= 7'h31;
        osdly <= 5'h01;
        look(900);
        check("os early", 32'h0, {31'h0, os_f});
        wait_flag(1, 400);
        @(posedge clk);
        oslvl <= 7'h78;
        osdly <= 5'h00;
        clear_faults();
        // speed error, reference opposite to feedback
        @(posedge clk);
        run <= 1'b1;
        sref <= 16'hEC78;
        look(1500);
        check("dev unarmed", 32'h0, {31'h0, dev_f});
        @(posedge clk);
        agree <= 1'b1;
        wait_flag(2, 300);
        check_stop(ESS_FAST);
        @(posedge clk);
        sref <= 16'h1388;
        clear_faults();
        look(300);
        check("dev matched", 32'h0, {31'h0, dev_f});
        // open circuit with encoder stopped, then with slow encoder edges
        @(posedge clk);
        run <= 1'b0;
        agree <= 1'b0;
        @(posedge clk);
        run <= 1'b1;
        sref <= 16'h0064;
        enc_en <= 1'b0;
        look(900);
        check("open early", 32'h0, {31'h0, open_f});
        wait_flag(0, 400);
        check_stop(ESS_COAST);
        @(posedge clk);
        sref <= 16'h0063;
        clear_faults();
        look(1500);
        check("open low ref", 32'h0, {31'h0, open_f});
        @(posedge clk);
        sref <= 16'h0064;
        brake <= 1'b1;
        look(1500);
        check("open braking", 32'h0, {31'h0, open_f});
        @(posedge clk);
        brake <= 1'b0;
        quarter <= 16'h02BC;
        enc_en <= 1'b1;
        look(3000);
        check("open slow edges", 32'h0, {31'h0, open_f});
        end_sim();
    end
endmodule
